// ---- core/tlbld_map.svh ----
// Field positions, decode values and reset values of the TLB lockdown block
`ifndef TLBLD_MAP_SVH
`define TLBLD_MAP_SVH

// ----------------------------------------------------------------
// Lockdown register fields
// ----------------------------------------------------------------
`define TLBLD_BASE_MSB     31
`define TLBLD_BASE_LSB     27
`define TLBLD_VICTIM_MSB   26
`define TLBLD_VICTIM_LSB   22
`define TLBLD_RETAIN_BIT   0
`define TLBLD_BASE_RST     5'h00
`define TLBLD_VICTIM_RST   5'h00
`define TLBLD_RETAIN_RST   1'b0

// ----------------------------------------------------------------
// Coprocessor decode
// ----------------------------------------------------------------
`define TLBLD_CRN_LOCK     4'ha
`define TLBLD_OPC1_LOCK    3'h0
`define TLBLD_CRM_LOCKREG  4'h0
`define TLBLD_CRM_PRELOAD  4'h1
`define TLBLD_OPC2_DATA    3'h0
`define TLBLD_OPC2_INSTR   3'h1

// ----------------------------------------------------------------
// Fault recording
// ----------------------------------------------------------------
`define TLBLD_ICM_FAULT_FS 4'h4
`define TLBLD_ALIGN_MASK   32'hffff_fffc
`define TLBLD_ZERO_WORD    32'h0000_0000

`endif

// ---- core/tlbld_pkg.sv ----
// Types shared by the TLB lockdown and preload block
package tlbld_pkg;

  typedef enum logic [1:0] {
    TLBLD_IDLE = 2'b00,
    TLBLD_LOOK = 2'b01,
    TLBLD_WALK = 2'b10
  } tlbld_state_e;

  typedef enum logic {
    TLBLD_DATA  = 1'b0,
    TLBLD_INSTR = 1'b1
  } tlbld_side_e;

endpackage : tlbld_pkg

// ---- core/tlbld_top.sv ----
// TLB lockdown registers, round-robin victim selection and preload sequencer
`timescale 1ns/1ps
`include "tlbld_map.svh"

module tlbld_top #(
  parameter int unsigned TLB_ENTRIES = 32,
  parameter int unsigned DESC_W      = 32
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              cp_valid,
  input  wire logic              cp_write,
  input  wire logic [2:0]        cp_opc1,
  input  wire logic [3:0]        cp_crn,
  input  wire logic [3:0]        cp_crm,
  input  wire logic [2:0]        cp_opc2,
  input  wire logic [31:0]       cp_wdata,
  input  wire logic              cp_secure,
  input  wire logic              cp_priv,
  output logic                   cp_done,
  output logic                   cp_undef,
  output logic [31:0]            cp_rdata,
  input  wire logic              nonsecure_lock_grant,
  input  wire logic              translation_enable,
  input  wire logic              align_check_enable,
  output logic                   lookup_req,
  output logic                   lookup_side,
  output logic [31:0]            lookup_va,
  input  wire logic              lookup_done,
  input  wire logic              lookup_hit,
  output logic                   walk_req,
  output logic                   walk_side,
  output logic [31:0]            walk_va,
  input  wire logic              walk_done,
  input  wire logic              walk_fault,
  input  wire logic [3:0]        walk_fault_type,
  input  wire logic [DESC_W-1:0] walk_desc,
  input  wire logic              fill_data,
  input  wire logic              fill_instr,
  output logic                   tlb_wr_en,
  output logic                   tlb_wr_side,
  output logic [4:0]             tlb_wr_index,
  output logic [DESC_W-1:0]      tlb_wr_desc,
  output logic                   tlb_wr_retain,
  output logic                   tlb_wr_secure_only,
  output logic [4:0]             victim_data,
  output logic [4:0]             victim_instr,
  output logic [4:0]             lock_base_data,
  output logic [4:0]             lock_base_instr,
  output logic                   retain_data,
  output logic                   retain_instr,
  output logic                   data_abort,
  output logic [31:0]            data_fault_status_reg,
  output logic [31:0]            data_fault_address_reg,
  output logic [31:0]            instr_fault_status_reg
);

  localparam logic [4:0] LAST_ENTRY = 5'(TLB_ENTRIES - 1);

  // ----------------------------------------------------------------
  // Victim rotation
  // ----------------------------------------------------------------
  // wrap to base
  function automatic logic [4:0] tlbld_next_victim(
    input logic [4:0] victim,
    input logic [4:0] base
  );
    logic [4:0] nxt;
    nxt = victim + 5'h01;
    // locked entries skipped
    // Wrap ignores retain, so entries locked earlier stay protected
    if (victim == LAST_ENTRY) begin
      nxt = base;
    end
    return nxt;
  endfunction : tlbld_next_victim

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  tlbld_pkg::tlbld_state_e state_reg;
  tlbld_pkg::tlbld_state_e state_next;

  logic        idle;
  logic        c10_hit;
  logic        side_sel;
  logic        lock_acc;
  logic        pre_acc;
  logic        lock_ok;
  logic        pre_ok;
  logic        lock_wr;
  logic        pre_start;
  logic        pre_nop;
  logic [31:0] pre_va;
  logic        walk_ok;
  logic        walk_bad;
  logic        look_miss;
  logic        look_hit;

  assign idle      = (state_reg == tlbld_pkg::TLBLD_IDLE);
  assign c10_hit   = cp_valid && idle && (cp_crn == `TLBLD_CRN_LOCK) && (cp_opc1 == `TLBLD_OPC1_LOCK)
                     && ((cp_opc2 == `TLBLD_OPC2_DATA) || (cp_opc2 == `TLBLD_OPC2_INSTR));
  assign side_sel  = (cp_opc2 == `TLBLD_OPC2_INSTR);
  assign lock_acc  = c10_hit && (cp_crm == `TLBLD_CRM_LOCKREG);
  assign pre_acc   = c10_hit && (cp_crm == `TLBLD_CRM_PRELOAD);
  assign lock_ok   = cp_priv && (cp_secure || nonsecure_lock_grant);
  assign pre_ok    = cp_priv && cp_write;
  assign lock_wr   = lock_acc && lock_ok && cp_write;
  assign pre_nop   = pre_acc && pre_ok && !translation_enable;
  assign pre_start = pre_acc && pre_ok && translation_enable;
  assign pre_va    = align_check_enable ? (cp_wdata & `TLBLD_ALIGN_MASK) : cp_wdata;
  assign look_hit  = (state_reg == tlbld_pkg::TLBLD_LOOK) && lookup_done && lookup_hit;
  assign look_miss = (state_reg == tlbld_pkg::TLBLD_LOOK) && lookup_done && !lookup_hit;
  assign walk_ok   = (state_reg == tlbld_pkg::TLBLD_WALK) && walk_done && !walk_fault;
  assign walk_bad  = (state_reg == tlbld_pkg::TLBLD_WALK) && walk_done && walk_fault;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tlbld_pkg::TLBLD_IDLE: begin
        if (pre_start) begin
          state_next = tlbld_pkg::TLBLD_LOOK;
        end
      end
      tlbld_pkg::TLBLD_LOOK: begin
        if (look_hit) begin
          state_next = tlbld_pkg::TLBLD_IDLE;
        end else if (look_miss) begin
          state_next = tlbld_pkg::TLBLD_WALK;
        end
      end
      tlbld_pkg::TLBLD_WALK: begin
        if (walk_done) begin
          state_next = tlbld_pkg::TLBLD_IDLE;
        end
      end
      default: begin
        state_next = tlbld_pkg::TLBLD_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Lockdown registers, one per TLB
  // ----------------------------------------------------------------
  logic       side_reg;
  logic       sec_reg;
  logic [4:0] base_reg   [2];
  logic [4:0] victim_reg [2];
  logic       retain_reg [2];

  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_side
      logic sw_wr;
      logic fill;
      assign sw_wr = lock_wr && (side_sel == 1'(gs));
      assign fill  = (walk_ok && (side_reg == 1'(gs))) || ((gs == 0) ? fill_data : fill_instr);

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          base_reg[gs]   <= `TLBLD_BASE_RST;
          victim_reg[gs] <= `TLBLD_VICTIM_RST;
          retain_reg[gs] <= `TLBLD_RETAIN_RST;
        end else if (sw_wr) begin
          base_reg[gs]   <= cp_wdata[`TLBLD_BASE_MSB:`TLBLD_BASE_LSB];
          victim_reg[gs] <= cp_wdata[`TLBLD_VICTIM_MSB:`TLBLD_VICTIM_LSB];
          retain_reg[gs] <= cp_wdata[`TLBLD_RETAIN_BIT];
        end else if (fill) begin
          victim_reg[gs] <= tlbld_next_victim(victim_reg[gs], base_reg[gs]);
        end
      end
    end
  endgenerate

  logic [31:0] lock_rdata;
  assign lock_rdata = {base_reg[side_sel], victim_reg[side_sel], 21'h00_0000, retain_reg[side_sel]};

  // ----------------------------------------------------------------
  // Sequencer and coprocessor answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg   <= tlbld_pkg::TLBLD_IDLE;
      side_reg    <= tlbld_pkg::TLBLD_DATA;
      sec_reg     <= 1'b0;
      lookup_req  <= 1'b0;
      lookup_side <= 1'b0;
      lookup_va   <= `TLBLD_ZERO_WORD;
      walk_req    <= 1'b0;
      walk_side   <= 1'b0;
      walk_va     <= `TLBLD_ZERO_WORD;
      cp_done     <= 1'b0;
      cp_undef    <= 1'b0;
      cp_rdata    <= `TLBLD_ZERO_WORD;
    end else begin
      state_reg <= state_next;
      cp_done   <= (lock_acc || pre_acc) && !pre_start;
      cp_undef  <= (lock_acc && !lock_ok) || (pre_acc && !pre_ok);
      cp_rdata  <= (lock_acc && lock_ok && !cp_write) ? lock_rdata : `TLBLD_ZERO_WORD;
      if (pre_start) begin
        side_reg    <= side_sel;
        sec_reg     <= cp_secure;
        lookup_req  <= 1'b1;
        lookup_side <= side_sel;
        lookup_va   <= pre_va;
      end else if (look_hit || look_miss) begin
        lookup_req <= 1'b0;
      end
      if (look_miss) begin
        walk_req  <= 1'b1;
        walk_side <= side_reg;
        walk_va   <= lookup_va;
      end else if (walk_ok || walk_bad) begin
        walk_req <= 1'b0;
      end
      if (look_hit || walk_ok || walk_bad) begin
        cp_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // TLB fill and fault recording
  // ----------------------------------------------------------------
  logic [4:0] cur_victim;
  logic       cur_retain;
  assign cur_victim = victim_reg[side_reg];
  assign cur_retain = retain_reg[side_reg];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tlb_wr_en              <= 1'b0;
      tlb_wr_side            <= 1'b0;
      tlb_wr_index           <= 5'h00;
      tlb_wr_desc            <= '0;
      tlb_wr_retain          <= 1'b0;
      tlb_wr_secure_only     <= 1'b0;
      data_abort             <= 1'b0;
      data_fault_status_reg  <= `TLBLD_ZERO_WORD;
      data_fault_address_reg <= `TLBLD_ZERO_WORD;
      instr_fault_status_reg <= `TLBLD_ZERO_WORD;
    end else begin
      tlb_wr_en    <= walk_ok;
      data_abort   <= walk_bad;
      if (walk_ok) begin
        tlb_wr_side   <= side_reg;
        tlb_wr_index  <= cur_victim;
        tlb_wr_desc   <= walk_desc;
        tlb_wr_retain <= cur_retain;
        tlb_wr_secure_only <= cur_retain && sec_reg && !nonsecure_lock_grant;
      end
      if (walk_bad) begin
        data_fault_address_reg <= walk_va;
        if (side_reg == tlbld_pkg::TLBLD_DATA) begin
          data_fault_status_reg <= {28'h000_0000, walk_fault_type};
        end else begin
          data_fault_status_reg  <= {28'h000_0000, `TLBLD_ICM_FAULT_FS};
          instr_fault_status_reg <= {28'h000_0000, walk_fault_type};
        end
      end
    end
  end

  // Base and victim visible to the walker for non-preload fills
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      victim_data     <= `TLBLD_VICTIM_RST;
      victim_instr    <= `TLBLD_VICTIM_RST;
      lock_base_data  <= `TLBLD_BASE_RST;
      lock_base_instr <= `TLBLD_BASE_RST;
      retain_data     <= `TLBLD_RETAIN_RST;
      retain_instr    <= `TLBLD_RETAIN_RST;
    end else begin
      victim_data     <= victim_reg[0];
      victim_instr    <= victim_reg[1];
      lock_base_data  <= base_reg[0];
      lock_base_instr <= base_reg[1];
      retain_data     <= retain_reg[0];
      retain_instr    <= retain_reg[1];
    end
  end

endmodule : tlbld_top

// ---- test/tb_tlb_lockdown_and_preload.sv ----
// Self-checking bench for the TLB lockdown and preload block
`timescale 1ns/1ps
module tb_tlb_lockdown_and_preload;
  logic        clk = 1'b0, rst_b = 1'b0, cp_valid = 1'b0, cp_write = 1'b0, cp_secure = 1'b1, cp_priv = 1'b1;
  logic [2:0]  cp_opc1 = 3'h0, cp_opc2 = 3'h0;
  logic [3:0]  cp_crn = 4'ha, cp_crm = 4'h0, lat = 4'h0, ftype = 4'h0, walk_fault_type;
  logic [31:0] cp_wdata = 32'h0000_0000, desc = 32'h0000_0000, cp_rdata, lookup_va, walk_va, walk_desc, rd;
  logic [31:0] tlb_wr_desc, data_fault_status_reg, data_fault_address_reg, instr_fault_status_reg, wdesc;
  logic        nonsecure_lock_grant = 1'b0, translation_enable = 1'b1, align_check_enable = 1'b0;
  logic        hit = 1'b0, fault = 1'b0, fill_data = 1'b0, fill_instr = 1'b0, cp_done, cp_undef, lookup_req;
  logic        lookup_side, lookup_done, lookup_hit, walk_req, walk_side, walk_done, walk_fault, tlb_wr_en;
  logic        tlb_wr_side, tlb_wr_retain, tlb_wr_secure_only, retain_data, retain_instr, data_abort;
  logic        ud, we, ab, wret, wso;
  logic [4:0]  tlb_wr_index, victim_data, victim_instr, lock_base_data, lock_base_instr, widx;
  int          err_count = 0, compares = 0;

  tlbld_top i_tlbld_top (.*);
  tlbld_walker_model i_tlbld_walker_model (.*);

  always #5 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request pulsed one cycle; qualifiers held until the answer is captured
  task automatic op(input logic w, input logic [3:0] crm, input logic o2, input logic [31:0] d,
                    input logic s, input logic p);
    int n;
    n = 0;
    @(posedge clk);
    {cp_write, cp_crm, cp_opc2, cp_wdata, cp_secure, cp_priv, cp_valid} <= {w, crm, 2'b00, o2, d, s, p, 1'b1};
    @(posedge clk);
    cp_valid <= 1'b0;
    #1;
    while (cp_done !== 1'b1) begin
      n++;
      if (n > 40) begin
        err_count++;
        tally_and_finish();
      end
      @(posedge clk);
      #1;
    end
    {rd, ud, we, widx, wdesc, wret, wso, ab} = {cp_rdata, cp_undef, tlb_wr_en, tlb_wr_index, tlb_wr_desc,
                                                tlb_wr_retain, tlb_wr_secure_only, data_abort};
  endtask : op

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    op(1'b0, 4'h0, 1'b0, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h0000_0000);
    op(1'b0, 4'h0, 1'b1, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h0000_0000);
  endtask : t_reset

  task automatic t_lock;
    // victim kept at or above base
    op(1'b1, 4'h0, 1'b0, 32'h10c0_0001, 1'b1, 1'b1);
    op(1'b1, 4'h0, 1'b1, 32'h0840_0000, 1'b1, 1'b1);
    op(1'b0, 4'h0, 1'b0, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h10c0_0001);
    chk({lock_base_data, lock_base_instr, retain_data, retain_instr, victim_instr},
        {5'h02, 5'h01, 1'b1, 1'b0, 5'h01});
    op(1'b0, 4'h0, 1'b1, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h0840_0000);
  endtask : t_lock

  task automatic t_access;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      nonsecure_lock_grant <= i[3];
      op(i[0], 4'h0, 1'b0, 32'h10c0_0001, i[1], i[2]);
      chk(ud, !i[2] || (!i[1] && !i[3]));
    end
  endtask : t_access

  task automatic t_miss;
    {lat, hit, fault, desc} = {4'h3, 1'b0, 1'b0, 32'h1234_5678};
    op(1'b1, 4'h1, 1'b0, 32'h0000_4000, 1'b0, 1'b1);
    chk({we, widx, wdesc, wret, ab}, {1'b1, 5'h03, 32'h1234_5678, 1'b1, 1'b0});
    op(1'b0, 4'h0, 1'b0, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h1100_0001);
    @(posedge clk);
    {fill_data, fill_instr} <= 2'b11;
    @(posedge clk);
    {fill_data, fill_instr} <= 2'b00;
    op(1'b0, 4'h0, 1'b0, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h1140_0001);
    op(1'b0, 4'h0, 1'b1, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h0880_0000);
  endtask : t_miss

  task automatic t_hit;
    {hit, lat} = {1'b1, 4'h0};
    op(1'b1, 4'h1, 1'b1, 32'h0000_2000, 1'b1, 1'b1);
    chk(we, 1'b0);
  endtask : t_hit

  task automatic t_fault;
    @(posedge clk);
    align_check_enable <= 1'b1;
    {hit, fault, ftype} <= {1'b0, 1'b1, 4'h7};
    op(1'b1, 4'h1, 1'b1, 32'h0000_8003, 1'b1, 1'b1);
    chk({ab, we, data_fault_status_reg[3:0], instr_fault_status_reg[3:0]}, {2'b10, 4'h4, 4'h7});
    chk({lookup_side, walk_side, lookup_va}, {1'b1, 1'b1, 32'h0000_8000});
    chk(data_fault_address_reg, 32'h0000_8000);
    ftype = 4'h5;
    op(1'b1, 4'h1, 1'b0, 32'h0000_c000, 1'b1, 1'b1);
    chk({ab, data_fault_status_reg[3:0], data_fault_address_reg}, {1'b1, 4'h5, 32'h0000_c000});
  endtask : t_fault

  task automatic t_nop;
    @(posedge clk);
    translation_enable <= 1'b0;
    fault <= 1'b0;
    op(1'b1, 4'h1, 1'b0, 32'h0000_4000, 1'b1, 1'b1);
    chk({we, ud}, 2'b00);
    @(posedge clk);
    translation_enable <= 1'b1;
    op(1'b1, 4'h1, 1'b0, 32'h0000_4000, 1'b1, 1'b0);
    chk({we, ud}, 2'b01);
  endtask : t_nop

  task automatic t_wrap;
    @(posedge clk);
    nonsecure_lock_grant <= 1'b0;
    op(1'b1, 4'h0, 1'b0, 32'h17c0_0001, 1'b1, 1'b1);
    op(1'b1, 4'h1, 1'b0, 32'h0001_0000, 1'b1, 1'b1);
    chk({widx, wso}, {5'h1f, 1'b1});
    op(1'b0, 4'h0, 1'b0, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h1080_0001);
    op(1'b1, 4'h0, 1'b1, 32'h0fc0_0000, 1'b1, 1'b1);
    op(1'b1, 4'h1, 1'b1, 32'h0002_0000, 1'b0, 1'b1);
    chk({we, tlb_wr_side, widx, wret, wso}, {2'b11, 5'h1f, 2'b00});
    op(1'b0, 4'h0, 1'b1, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h0840_0000);
  endtask : t_wrap

  task automatic t_rerst;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    op(1'b0, 4'h0, 1'b1, 32'h0000_0000, 1'b1, 1'b1);
    chk(rd, 32'h0000_0000);
    chk({victim_data, lock_base_data, retain_data, victim_instr, tlb_wr_en, data_abort, data_fault_status_reg},
        50'h0);
  endtask : t_rerst

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_lock();
    t_access();
    t_miss();
    t_hit();
    t_fault();
    t_nop();
    t_wrap();
    t_rerst();
    tally_and_finish();
  end
endmodule : tb_tlb_lockdown_and_preload

// ---- test/tlbld_properties.sv ----
// Port-level assertions for the TLB lockdown and preload block
`timescale 1ns/1ps
module tlbld_properties (
  input logic       clk,
  input logic       rst_b,
  input logic       cp_done,
  input logic       cp_undef,
  input logic       cp_write,
  input logic       cp_priv,
  input logic       cp_secure,
  input logic [3:0] cp_crm,
  input logic       nonsecure_lock_grant,
  input logic       translation_enable,
  input logic       lookup_req,
  input logic       lookup_done,
  input logic       lookup_hit,
  input logic       walk_req,
  input logic       walk_done,
  input logic       walk_fault,
  input logic       tlb_wr_en,
  input logic       tlb_wr_side,
  input logic [4:0] tlb_wr_index,
  input logic [4:0] victim_data,
  input logic [4:0] victim_instr,
  input logic [4:0] lock_base_data,
  input logic [4:0] lock_base_instr,
  input logic       data_abort
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_user_undef: assert property (cp_done && !cp_priv |-> cp_undef)
    else $error("user mode op not refused");
  a_lock_access: assert property (cp_done && cp_priv && cp_crm == 4'h0
    |-> cp_undef == (!cp_secure && !nonsecure_lock_grant))
    else $error("lockdown access verdict wrong");
  a_preload_ok: assert property (cp_done && cp_priv && cp_write && cp_crm == 4'h1 |-> !cp_undef)
    else $error("privileged preload refused");
  a_nop_lookup: assert property ($rose(lookup_req) |-> $past(translation_enable && cp_priv))
    else $error("lookup without enabled privileged preload");
  a_walk_miss: assert property ($rose(walk_req) |-> $past(lookup_done && !lookup_hit))
    else $error("walk started without a miss");
  a_fill_victim: assert property (tlb_wr_en |-> $past(walk_done && !walk_fault)
    && tlb_wr_index == (tlb_wr_side ? victim_instr : victim_data))
    else $error("fill not at victim after clean walk");
  a_victim_step: assert property (tlb_wr_en && tlb_wr_index != 5'h1f
    |=> (tlb_wr_side ? victim_instr : victim_data) == tlb_wr_index + 5'h01)
    else $error("victim did not advance by one");
  a_victim_wrap: assert property (tlb_wr_en && tlb_wr_index == 5'h1f
    |=> (tlb_wr_side ? victim_instr : victim_data) == (tlb_wr_side ? lock_base_instr : lock_base_data))
    else $error("victim did not wrap to base");
  a_abort_cause: assert property (data_abort |-> $past(walk_done && walk_fault))
    else $error("abort without faulting walk");
endmodule : tlbld_properties

bind tlbld_top tlbld_properties i_tlbld_properties (.*);

// ---- test/tlbld_walker_model.sv ----
// Behavioural TLB lookup and table walker answering the preload link
`timescale 1ns/1ps
module tlbld_walker_model (
  input  logic        clk,
  input  logic        lookup_req,
  input  logic        walk_req,
  input  logic [3:0]  lat,
  input  logic        hit,
  input  logic        fault,
  input  logic [3:0]  ftype,
  input  logic [31:0] desc,
  output logic        lookup_done,
  output logic        lookup_hit,
  output logic        walk_done,
  output logic        walk_fault,
  output logic [3:0]  walk_fault_type,
  output logic [31:0] walk_desc
);
  logic [3:0] cnt = 4'h0;
  initial {lookup_done, walk_done} = 2'b00;
  always @(posedge clk) begin
    {lookup_done, walk_done} <= 2'b00;
    // Off-pulse qualifiers inverted, stale values never pass as answers
    {lookup_hit, walk_fault, walk_fault_type, walk_desc} <= ~{hit, fault, ftype, desc};
    if ((lookup_req || walk_req) && !lookup_done && !walk_done) begin
      cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
      if (cnt == lat) begin
        {lookup_done, walk_done} <= {lookup_req, walk_req};
        {lookup_hit, walk_fault, walk_fault_type, walk_desc} <= {hit, fault, ftype, desc};
      end
    end
  end
endmodule : tlbld_walker_model
